// [asfsf_pkg.sv]
// Overview of operation
// R1 - Busy flag sets on first word load
// R2 - Busy clears once FIFO and shifter drained
// R3 - Empty flag high when FIFO holds none
// R4 - Full flag high when FIFO holds eight
// R5 - Watermark flag sets at level <= threshold
// R6 - Watermark holds until write lifts level above
// R7 - Overrun flag sets on write when full
// R8 - Starve flag sets on fetch when empty
// R9 - Writing one clears overrun/starve; zero ignored
// R10 - Receive empty flag high at zero words
// R11 - Read-only status flags ignore software writes
// R12 - Status bits 15 to 13 read zero
// R13 - Fill count reported in bits 31:28
// R14 - Interrupt on overrun when its enable set
// R15 - Hardware set beats simultaneous software clear
package asfsf_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_TX_DATA = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h18;
	localparam int unsigned ST_LEVEL_LO = 28;
	localparam int unsigned ST_BUSY = 21;
	localparam int unsigned ST_TX_EMPTY = 20;
	localparam int unsigned ST_TX_FULL = 19;
	localparam int unsigned ST_WM = 18;
	localparam int unsigned ST_OVR = 17;
	localparam int unsigned ST_STARVE = 16;
	localparam int unsigned ST_RX_EMPTY = 12;
	localparam int unsigned CTRL_WM_W = 3;
	localparam int unsigned IRQ_N = 3;
	localparam int unsigned IRQ_OVR = 0;
	localparam int unsigned IRQ_STARVE = 1;
	localparam int unsigned IRQ_WM = 2;
	localparam logic [CTRL_WM_W-1:0] CTRL_RESET = 3'h0;
	localparam logic [IRQ_N-1:0] IRQ_EN_RESET = 3'h0;
	localparam int unsigned TX_DEPTH = 8;
	localparam int unsigned LEVEL_W = 4;
endpackage

// [asfsf_mem_if.sv]
`timescale 1ns/1ps
interface asfsf_mem_if #(
	parameter int unsigned W = 32,
	parameter int unsigned AW = 3
);
	logic we;
	logic [AW-1:0] waddr;
	logic [W-1:0] wdata;
	logic re;
	logic [AW-1:0] raddr;
	logic [W-1:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output re,
		output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input re,
		input raddr, output rdata);
endinterface

// [asfsf_mem.sv]
`timescale 1ns/1ps
module asfsf_mem #(
	parameter int unsigned W = 32,
	parameter int unsigned AW = 3
)(
	// Clock
	input wire logic clk_sys_i,
	// Port
	asfsf_mem_if.mem port
);
	logic [W-1:0] store [2**AW];
	logic [W-1:0] rdata;

	// No reset on the array: storage only, saves area
	always_ff @(posedge clk_sys_i)
	begin
		if (port.we)
		begin
			store[port.waddr] <= port.wdata;
		end
		if (port.re)
		begin
			rdata <= store[port.raddr];
		end
	end

	assign port.rdata = rdata;
endmodule

// [asfsf_top.sv]
`timescale 1ns/1ps
module asfsf_top
	import asfsf_pkg::*;
#(
	parameter int unsigned DEPTH = TX_DEPTH,
	parameter int unsigned WORD_W = DATA_W
)(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	// Serial shift logic side
	input wire logic shift_fetch_i,
	input wire logic shift_drained_i,
	output logic [WORD_W-1:0] tx_word_o,
	// Receive side
	input wire logic [LEVEL_W-1:0] rx_fill_count_i,
	// Interrupt
	output logic irq_o
);
	localparam int unsigned AW = $clog2(DEPTH);

	// Level field and full compare are sized for eight words,
	// so any other depth is refused when the design is built
	if (DEPTH != TX_DEPTH || WORD_W > DATA_W || WORD_W == 0)
	begin
		$error("asfsf_top: unsupported DEPTH or WORD_W");
	end

	asfsf_mem_if #(.W(WORD_W), .AW(AW)) mem_port ();

	asfsf_mem #(
		.W(WORD_W),
		.AW(AW)
	) u_mem (
		.clk_sys_i(clk_sys_i),
		.port(mem_port.mem)
	);

	// FIFO pointers carry one extra bit so full and empty differ
	logic [AW:0] wptr;
	logic [AW:0] rptr;
	logic [AW:0] next_wptr;
	logic [AW:0] next_rptr;
	logic [LEVEL_W-1:0] tx_fill_count;
	logic [LEVEL_W-1:0] next_fill;
	logic tx_queue_vacant;
	logic tx_queue_packed;
	logic push_req;
	logic push_ok;
	logic pop_ok;

	// Flags and control
	logic tx_shifter_active;
	logic next_active;
	logic tx_watermark_flag;
	logic next_wm;
	logic wm_wr_seen;
	logic next_wm_wr_seen;
	logic tx_overrun_flag;
	logic next_overrun;
	logic tx_starve_flag;
	logic next_starve;
	logic [CTRL_WM_W-1:0] tx_watermark_level;
	logic [CTRL_WM_W-1:0] next_wm_level;
	logic [IRQ_N-1:0] irq_enable;
	logic [IRQ_N-1:0] next_irq_enable;
	logic wm_event;
	logic next_wm_event;
	logic [IRQ_N-1:0] irq_status;
	logic [DATA_W-1:0] status_word;
	logic [DATA_W-1:0] next_rdata;
	logic rx_queue_vacant;
	logic clr_overrun;
	logic clr_starve;
	logic clr_wm_event;
	logic wr_status;
	logic wr_irq_clr;

	// FIFO occupancy
	assign tx_fill_count = LEVEL_W'(wptr - rptr);
	assign tx_queue_vacant = (tx_fill_count == '0); // R3
	assign tx_queue_packed = (tx_fill_count == LEVEL_W'(DEPTH)); // R4
	assign rx_queue_vacant = (rx_fill_count_i == '0); // R10

	assign push_req = reg_wr_i && (reg_addr_i == OFS_TX_DATA);
	// Writes into a full FIFO are dropped, the word is lost
	assign push_ok = push_req && !tx_queue_packed;
	assign pop_ok = shift_fetch_i && !tx_queue_vacant;

	assign mem_port.we = push_ok;
	assign mem_port.waddr = wptr[AW-1:0];
	assign mem_port.wdata = reg_wdata_i[WORD_W-1:0];
	assign mem_port.re = pop_ok;
	assign mem_port.raddr = rptr[AW-1:0];
	assign tx_word_o = mem_port.rdata;

	always_comb
	begin
		next_wptr = wptr;
		next_rptr = rptr;
		if (push_ok)
		begin
			next_wptr = wptr + 1'b1;
		end
		if (pop_ok)
		begin
			next_rptr = rptr + 1'b1;
		end
		next_fill = LEVEL_W'(next_wptr - next_rptr);
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wptr <= '0;
			rptr <= '0;
		end
		else
		begin
			wptr <= next_wptr;
			rptr <= next_rptr;
		end
	end

	// Software write decode
	assign wr_status = reg_wr_i && (reg_addr_i == OFS_STATUS);
	assign wr_irq_clr = reg_wr_i && (reg_addr_i == OFS_IRQ_CLR);
	assign clr_overrun = (wr_status && reg_wdata_i[ST_OVR])
		|| (wr_irq_clr && reg_wdata_i[IRQ_OVR]); // R9
	assign clr_starve = (wr_status && reg_wdata_i[ST_STARVE])
		|| (wr_irq_clr && reg_wdata_i[IRQ_STARVE]); // R9
	assign clr_wm_event = wr_irq_clr && reg_wdata_i[IRQ_WM];

	// Flag next-state logic
	always_comb
	begin
		next_active = tx_shifter_active;
		if (pop_ok)
		begin
			next_active = 1'b1; // R1
		end
		else if (tx_queue_vacant && shift_drained_i)
		begin
			next_active = 1'b0; // R2
		end

		// Set is tested last so it wins over a clear in the same cycle
		next_overrun = tx_overrun_flag;
		if (clr_overrun)
		begin
			next_overrun = 1'b0;
		end
		if (push_req && tx_queue_packed)
		begin
			next_overrun = 1'b1; // R7 R15
		end

		next_starve = tx_starve_flag;
		if (clr_starve)
		begin
			next_starve = 1'b0;
		end
		if (shift_fetch_i && tx_queue_vacant)
		begin
			next_starve = 1'b1; // R8 R15
		end

		// Watermark holds until a data write lifts the level above it
		next_wm = tx_watermark_flag;
		next_wm_wr_seen = wm_wr_seen || push_req;
		if (next_fill <= LEVEL_W'(tx_watermark_level))
		begin
			next_wm = 1'b1; // R5
			next_wm_wr_seen = 1'b0;
		end
		else if (next_wm_wr_seen)
		begin
			next_wm = 1'b0; // R6
		end

		next_wm_event = wm_event;
		if (clr_wm_event)
		begin
			next_wm_event = 1'b0;
		end
		if (next_wm && !tx_watermark_flag)
		begin
			next_wm_event = 1'b1; // R15
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_shifter_active <= 1'b0;
			tx_overrun_flag <= 1'b0;
			tx_starve_flag <= 1'b0;
			tx_watermark_flag <= 1'b1;
			wm_wr_seen <= 1'b0;
			wm_event <= 1'b0;
		end
		else
		begin
			tx_shifter_active <= next_active;
			tx_overrun_flag <= next_overrun;
			tx_starve_flag <= next_starve;
			tx_watermark_flag <= next_wm;
			wm_wr_seen <= next_wm_wr_seen;
			wm_event <= next_wm_event;
		end
	end

	// Control registers
	always_comb
	begin
		next_wm_level = tx_watermark_level;
		next_irq_enable = irq_enable;
		if (reg_wr_i && (reg_addr_i == OFS_CTRL))
		begin
			next_wm_level = reg_wdata_i[CTRL_WM_W-1:0];
		end
		if (reg_wr_i && (reg_addr_i == OFS_IRQ_EN))
		begin
			next_irq_enable = reg_wdata_i[IRQ_N-1:0];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_watermark_level <= CTRL_RESET;
			irq_enable <= IRQ_EN_RESET;
		end
		else
		begin
			tx_watermark_level <= next_wm_level;
			irq_enable <= next_irq_enable;
		end
	end

	// Interrupt: overrun and starve share the status flags
	assign irq_status = {wm_event, tx_starve_flag, tx_overrun_flag};
	assign irq_o = |(irq_status & irq_enable); // R14

	// Status word; read-only bits have no write path
	always_comb
	begin
		status_word = '0; // R12
		status_word[ST_LEVEL_LO +: LEVEL_W] = tx_fill_count; // R13
		status_word[ST_BUSY] = tx_shifter_active; // R11
		status_word[ST_TX_EMPTY] = tx_queue_vacant;
		status_word[ST_TX_FULL] = tx_queue_packed;
		status_word[ST_WM] = tx_watermark_flag;
		status_word[ST_OVR] = tx_overrun_flag;
		status_word[ST_STARVE] = tx_starve_flag;
		status_word[ST_RX_EMPTY] = rx_queue_vacant;
	end

	// Read data valid only in the cycle after the strobe
	always_comb
	begin
		next_rdata = '0;
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				OFS_CTRL:
				begin
					next_rdata[CTRL_WM_W-1:0] = tx_watermark_level;
				end
				OFS_STATUS:
				begin
					next_rdata = status_word;
				end
				OFS_IRQ_STAT:
				begin
					next_rdata[IRQ_N-1:0] = irq_status;
				end
				OFS_IRQ_EN:
				begin
					next_rdata[IRQ_N-1:0] = irq_enable;
				end
				default:
				begin
					next_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			reg_rdata_o <= '0;
		end
		else
		begin
			reg_rdata_o <= next_rdata;
		end
	end
endmodule

// [asfsf_top_monitor.sv]
`timescale 1ns/1ps
module asfsf_top_monitor
	import asfsf_pkg::*;
#(
	parameter int unsigned DEPTH = TX_DEPTH,
	parameter int unsigned WORD_W = DATA_W
)(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [DATA_W-1:0] reg_rdata_o,
	// Shift side
	input wire logic shift_fetch_i,
	input wire logic shift_drained_i,
	input wire logic [WORD_W-1:0] tx_word_o,
	// Receive side and interrupt
	input wire logic [LEVEL_W-1:0] rx_fill_count_i,
	input wire logic irq_o
);
	logic st_rd;
	logic rx_zero;
	logic tx_loaded;
	logic [3:0] lvl;
	assign lvl = reg_rdata_o[31:28];
	// Status read data lands one cycle after the strobe
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_rd <= 1'b0;
			rx_zero <= 1'b0;
			tx_loaded <= 1'b0;
		end
		else
		begin
			st_rd <= reg_rd_i && reg_addr_i == OFS_STATUS;
			rx_zero <= rx_fill_count_i == 4'h0;
			// Busy seen means a word was loaded, so the word is known
			if (st_rd && reg_rdata_o[21])
			begin
				tx_loaded <= 1'b1;
			end
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	property p_resv;
		st_rd |-> reg_rdata_o[15:13] == 3'h0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved set");
	property p_low;
		st_rd |-> reg_rdata_o[11:0] == 12'h0;
	endproperty
	a_low: assert property (p_low) else $error("low bits set");
	property p_empty;
		st_rd |-> reg_rdata_o[20] == (lvl == 4'h0);
	endproperty
	a_empty: assert property (p_empty) else $error("empty wrong");
	property p_full;
		st_rd |-> reg_rdata_o[19] == (lvl == 4'h8);
	endproperty
	a_full: assert property (p_full) else $error("full wrong");
	property p_level;
		st_rd |-> lvl <= 4'h8;
	endproperty
	a_level: assert property (p_level) else $error("level big");
	property p_rxe;
		st_rd |-> reg_rdata_o[12] == rx_zero;
	endproperty
	a_rxe: assert property (p_rxe) else $error("rx empty wrong");
	property p_wm;
		st_rd && lvl == 4'h0 |-> reg_rdata_o[18];
	endproperty
	a_wm: assert property (p_wm) else $error("watermark low");
	property p_irq;
		irq_o && !reg_wr_i |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("irq dropped");
	property p_hold;
		tx_loaded && !shift_fetch_i |=> $stable(tx_word_o);
	endproperty
	a_hold: assert property (p_hold) else $error("tx word moved");
endmodule

bind asfsf_top asfsf_top_monitor #(.DEPTH(DEPTH), .WORD_W(WORD_W))
	asfsf_top_monitor_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.shift_fetch_i(shift_fetch_i), .shift_drained_i(shift_drained_i),
	.tx_word_o(tx_word_o), .rx_fill_count_i(rx_fill_count_i),
	.irq_o(irq_o));

// [asfsf_codec_model.sv]
`timescale 1ns/1ps
module asfsf_codec_model #(
	parameter int SHIFT_CYC = 4
)(
	// Clock and command
	input wire logic clk_sys_i,
	input wire logic pull_i,
	// Shift side
	output logic shift_fetch_o,
	output logic shift_drained_o
);
	int left = 0;
	initial shift_fetch_o = 1'b0;
	// Fetches even on an empty queue, as real shift logic would
	always @(posedge clk_sys_i)
	begin
		shift_fetch_o <= pull_i;
		if (pull_i)
			left <= SHIFT_CYC;
		else if (left > 0)
			left <= left - 1;
	end
	assign shift_drained_o = (left == 0);
endmodule

// [audio_serial_fifo_status_flags_tb_top.sv]
`timescale 1ns/1ps
module audio_serial_fifo_status_flags_tb_top;
	import asfsf_pkg::*;
	typedef struct packed {
		logic [3:0] nwr;
		logic [3:0] npull;
		logic [31:0] st;
		logic [31:0] tx;
	} asfsf_row_t;
	asfsf_row_t rows [7] = '{
		'{4'h1, 4'h0, 32'h1004_0000, 32'h0},
		'{4'h2, 4'h0, 32'h3000_0000, 32'h0},
		'{4'h0, 4'h1, 32'h2024_0000, 32'ha0},
		'{4'h6, 4'h0, 32'h8028_0000, 32'h0},
		'{4'h1, 4'h0, 32'h802a_0000, 32'h0},
		'{4'h0, 4'h8, 32'h0016_0000, 32'ha8},
		'{4'h0, 4'h1, 32'h0017_0000, 32'h0}};
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic shift_fetch_i;
	logic shift_drained_i;
	logic [31:0] tx_word_o;
	logic [3:0] rx_fill_count_i = 4'h3;
	logic irq_o;
	logic pull = 1'b0;
	logic [31:0] v;
	int idx = 0;
	int fail_count = 0;
	int check_count = 0;
	asfsf_top asfsf_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.shift_fetch_i(shift_fetch_i), .shift_drained_i(shift_drained_i),
		.tx_word_o(tx_word_o), .rx_fill_count_i(rx_fill_count_i),
		.irq_o(irq_o));
	asfsf_codec_model asfsf_codec_model_inst (.clk_sys_i(clk_sys_i),
		.pull_i(pull), .shift_fetch_o(shift_fetch_i),
		.shift_drained_o(shift_drained_i));
	initial
	begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	task automatic pull_n(input logic [3:0] n);
		@(posedge clk_sys_i);
		pull <= 1'b1;
		repeat (n) @(posedge clk_sys_i);
		pull <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_irq(input logic exp);
		@(negedge clk_sys_i);
		check_count++;
		if (irq_o !== exp)
		begin
			fail_count++;
			$display("BAD %0t irq %b exp %b", $time, irq_o, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		fail_count++;
		end_of_test();
	end
	initial
	begin
		repeat (8) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(OFS_STATUS, v);
		chk(v, 32'h0014_0000);
		wr(OFS_CTRL, 32'h2);
		foreach (rows[i])
		begin
			repeat (rows[i].nwr)
			begin
				wr(OFS_TX_DATA, 32'ha0 + idx);
				idx++;
			end
			if (rows[i].npull != 4'h0)
				pull_n(rows[i].npull);
			rd(OFS_STATUS, v);
			chk(v, rows[i].st);
			if (rows[i].tx != 32'h0)
				chk(tx_word_o, rows[i].tx);
		end
		rd(OFS_IRQ_STAT, v);
		chk(v, 32'h7);
		wr(OFS_IRQ_EN, 32'h1);
		chk_irq(1'b1);
		wr(OFS_IRQ_EN, 32'h0);
		chk_irq(1'b0);
		wr(OFS_IRQ_EN, 32'h1);
		wr(OFS_IRQ_CLR, 32'h1);
		chk_irq(1'b0);
		wr(OFS_STATUS, 32'h003c_0000);
		rd(OFS_STATUS, v);
		chk(v, 32'h0015_0000);
		wr(OFS_STATUS, 32'h0001_0000);
		rd(OFS_STATUS, v);
		chk(v, 32'h0014_0000);
		// Fetch on empty lands on the same edge as the clear
		@(posedge clk_sys_i);
		pull <= 1'b1;
		@(posedge clk_sys_i);
		pull <= 1'b0;
		reg_addr_i <= OFS_STATUS;
		reg_wdata_i <= 32'h0001_0000;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		rx_fill_count_i <= 4'h0;
		repeat (8) @(posedge clk_sys_i);
		rd(OFS_STATUS, v);
		chk(v, 32'h0015_1000);
		rd(8'h08, v);
		chk(v, 32'h0);
		// Reset in mid-run drops the sticky starve flag
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(OFS_STATUS, v);
		chk(v, 32'h0014_1000);
		chk_irq(1'b0);
		end_of_test();
	end
endmodule
